// file: touch_status_consts.svh
// constants for the controller status register block
// assumes inclusion by touch_status_pkg.sv and touch_status_register.sv
`ifndef TOUCH_STATUS_CONSTS_SVH
`define TOUCH_STATUS_CONSTS_SVH

`define STATUS_REG_ADDR    4'h8
`define STATUS_RESET_VALUE 16'h0004
`define FLAG_X_BIT         15
`define FLAG_Y_BIT         14
`define FLAG_Z1_BIT        13
`define FLAG_Z2_BIT        12
`define FLAG_AUX_BIT       11
`define RESET_HIST_BIT     7
`define BIAS_OFF_BIT       2
`define NUM_RESULT_FLAGS   5

`endif

// file: touch_status_pkg.sv
// types for the controller status register block
// assumes touch_status_consts.svh is on the include path
`include "touch_status_consts.svh"
package touch_status_pkg;
  // one bit per result type: x, y, z1, z2, aux (msb first)
  typedef struct packed {
    logic x;
    logic y;
    logic z1;
    logic z2;
    logic aux;
  } result_flags_s;

  // register read port
  typedef struct packed {
    logic       rd;
    logic [3:0] addr;
  } reg_read_s;

  // bias supply states
  typedef enum logic [1:0] {
    BIAS_OFF = 2'b01,
    BIAS_ON  = 2'b10
  } bias_state_e;
endpackage

// file: touch_status_register.sv
// controller status register of the resistive touch controller
// assumes all inputs come from logic on mclk; serial bus decoded upstream
//
// Functional notes
// - status register sits at address 8h, reset value 0004h
// - storing processed results sets matching flag: x15 y14 z1 13 z2 12 aux11
// - flag stays set until host reads its own matching data register
// - single x or y plate current conversion uses flag 15 or 14 only
// - bit 7 reads 0 after reset until next status poll, then 1
// - bit 2 mirrors bias power-down select of first control byte
// - adc bias always off between complete conversion sets
// - bit 2 takes new setting only at pen touch or converter start
`timescale 1ns/100ps
`default_nettype none
`include "touch_status_consts.svh"

module touch_status_register
(
  // clock and reset
  input  wire logic                           mclk,
  input  wire logic                           sys_rst,
  // software reset from control byte
  input  wire logic                           soft_rst,
  // result storage and host reads of data registers
  input  wire touch_status_pkg::result_flags_s result_store,
  input  wire touch_status_pkg::result_flags_s result_read,
  // host register read and write
  input  wire touch_status_pkg::reg_read_s    host_rd,
  input  wire logic                           host_wr,
  // bias control
  input  wire logic                           bias_power_down_select,
  input  wire logic                           pen_touch,
  input  wire logic                           conv_start,
  input  wire logic                           conv_active,
  input  wire logic                           set_done,
  // outputs
  output logic [15:0]                         rd_data,
  output logic                                bias_on
);

  touch_status_pkg::result_flags_s result_ready_flags;
  touch_status_pkg::bias_state_e   bias_state;
  logic                            reset_seen_n;
  logic                            bias_off_indicator;
  logic                            status_poll;
  logic [15:0]                     status_word;

  assign status_poll = host_rd.rd && (host_rd.addr == `STATUS_REG_ADDR);

  // data-available flags, set wins over clear
  always_ff @(posedge mclk)
  begin
    if (sys_rst || soft_rst)
      result_ready_flags <= '0;
    else
      result_ready_flags <= result_store
        | (result_ready_flags & ~result_read);
  end

  // reset history, cleared by any reset, set by a status poll
  always_ff @(posedge mclk)
  begin
    if (sys_rst || soft_rst)
      reset_seen_n <= 1'b0;
    else if (status_poll)
      reset_seen_n <= 1'b1;
  end

  // power-down status, sampled only at touch or converter start
  always_ff @(posedge mclk)
  begin
    if (sys_rst || soft_rst)
      bias_off_indicator <= 1'b1;
    else if (pen_touch || conv_start)
      bias_off_indicator <= bias_power_down_select;
  end

  // bias supply control
  always_ff @(posedge mclk)
  begin
    if (sys_rst || soft_rst)
      bias_state <= touch_status_pkg::BIAS_OFF;
    else
    begin
      unique case (bias_state)
        touch_status_pkg::BIAS_OFF:
          if (conv_start)
            bias_state <= touch_status_pkg::BIAS_ON;
        touch_status_pkg::BIAS_ON:
          if (set_done)
            bias_state <= touch_status_pkg::BIAS_OFF;
          else if (!conv_active && bias_off_indicator)
            bias_state <= touch_status_pkg::BIAS_OFF;
        default:
          bias_state <= touch_status_pkg::BIAS_OFF;
      endcase
      if (!set_done && !conv_start && conv_active
          && bias_state == touch_status_pkg::BIAS_OFF)
        bias_state <= touch_status_pkg::BIAS_ON;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      bias_on <= 1'b0;
    else
      bias_on <= (bias_state == touch_status_pkg::BIAS_ON);
  end

  // status word assembly, reserved bits zero
  always_comb
  begin
    status_word = 16'h0000;
    status_word[`FLAG_X_BIT:`FLAG_AUX_BIT] = result_ready_flags;
    status_word[`RESET_HIST_BIT] = reset_seen_n;
    status_word[`BIAS_OFF_BIT] = bias_off_indicator;
  end

  // read data register; writes never reach it
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rd_data <= `STATUS_RESET_VALUE;
    else if (status_poll)
      rd_data <= status_word;
  end

  property p_set_flag;
    @(posedge mclk) disable iff (sys_rst || soft_rst)
    result_store.x |=> result_ready_flags.x;
  endproperty
  a_set_flag: assert property (p_set_flag) else $error("x flag not set");

  property p_hold_flag;
    @(posedge mclk) disable iff (sys_rst || soft_rst)
    result_ready_flags.aux && !result_read.aux |=> result_ready_flags.aux;
  endproperty
  a_hold_flag: assert property (p_hold_flag) else $error("aux flag lost");

  property p_clear_flag;
    @(posedge mclk) disable iff (sys_rst || soft_rst)
    result_read.y && !result_store.y |=> !result_ready_flags.y;
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("y not cleared");

  property p_single_plate;
    @(posedge mclk) disable iff (sys_rst || soft_rst)
    result_store == 5'b10000 && result_ready_flags == '0
      |=> result_ready_flags == 5'b10000;
  endproperty
  a_single_plate: assert property (p_single_plate) else $error("extra flag");

  sequence s_poll;
    status_poll && !soft_rst;
  endsequence
  property p_history;
    @(posedge mclk) disable iff (sys_rst)
    s_poll ##1 !soft_rst |-> reset_seen_n;
  endproperty
  a_history: assert property (p_history) else $error("history not set");

  property p_soft_reset;
    @(posedge mclk) disable iff (sys_rst)
    soft_rst |=> !reset_seen_n && bias_off_indicator
      && result_ready_flags == '0;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("bad reset");

  property p_bias_hold;
    @(posedge mclk) disable iff (sys_rst || soft_rst)
    !pen_touch && !conv_start |=> $stable(bias_off_indicator);
  endproperty
  a_bias_hold: assert property (p_bias_hold) else $error("bit 2 moved");

  property p_bias_take;
    @(posedge mclk) disable iff (sys_rst || soft_rst)
    conv_start |=> bias_off_indicator == $past(bias_power_down_select);
  endproperty
  a_bias_take: assert property (p_bias_take) else $error("bit 2 stale");

  property p_set_off;
    @(posedge mclk) disable iff (sys_rst || soft_rst)
    set_done |=> ##1 !bias_on;
  endproperty
  a_set_off: assert property (p_set_off) else $error("bias on");

  property p_reserved;
    @(posedge mclk) disable iff (sys_rst)
    (rd_data & 16'h077B) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved set");

  property p_status_reset;
    @(posedge mclk)
    sys_rst |=> rd_data == `STATUS_RESET_VALUE && !bias_on;
  endproperty
  a_status_reset: assert property (p_status_reset)
    else $error("bad reset value");

  property p_write_ignored;
    @(posedge mclk) disable iff (sys_rst)
    host_wr && !status_poll |=> $stable(rd_data);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("write changed read data");

  property p_other_addr;
    @(posedge mclk) disable iff (sys_rst)
    host_rd.rd && host_rd.addr != `STATUS_REG_ADDR |=> $stable(rd_data);
  endproperty
  a_other_addr: assert property (p_other_addr)
    else $error("other address answered");

  property p_poll_flags;
    @(posedge mclk) disable iff (sys_rst)
    status_poll |=> rd_data[`FLAG_X_BIT:`FLAG_AUX_BIT]
      == $past(result_ready_flags);
  endproperty
  a_poll_flags: assert property (p_poll_flags)
    else $error("flags not reported");

  property p_poll_history;
    @(posedge mclk) disable iff (sys_rst)
    status_poll |=> rd_data[`RESET_HIST_BIT] == $past(reset_seen_n)
      && rd_data[`BIAS_OFF_BIT] == $past(bias_off_indicator);
  endproperty
  a_poll_history: assert property (p_poll_history)
    else $error("history not reported");

endmodule

`default_nettype wire

// file: host_model.sv
// host model: reads and writes the status block registers
// assumes mclk from the bench; one access at a time
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  // clock
  input  wire logic                   mclk,
  // register port
  output touch_status_pkg::reg_read_s host_rd,
  output logic                        host_wr,
  input  wire logic [15:0]            rd_data
);
  initial host_rd = '0;
  initial host_wr = 1'b0;
  task automatic read_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk) #1 host_rd = '{rd: 1'b1, addr: a};
    @(posedge mclk) #1 host_rd = '{rd: 1'b0, addr: ~a};
    @(posedge mclk) #1 d = rd_data;
  endtask
  task automatic write_reg();
    @(posedge mclk) #1 host_wr = 1'b1;
    @(posedge mclk) #1 host_wr = 1'b0;
  endtask
endmodule
`default_nettype wire

// file: touch_status_register_tb.sv
// bench for the status register block
// assumes the package and host_model are compiled first
`timescale 1ns/100ps
`default_nettype none
module touch_status_register_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_rst = 1'b0;
  logic sel = 1'b1;
  logic pen_touch = 1'b0;
  logic conv_start = 1'b0;
  logic conv_active = 1'b0;
  logic set_done = 1'b0;
  logic host_wr;
  logic bias_on;
  logic [15:0] rd_data;
  logic [15:0] d;
  touch_status_pkg::result_flags_s st = '0;
  touch_status_pkg::result_flags_s rr = '0;
  touch_status_pkg::reg_read_s host_rd;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  always #5 mclk = ~mclk;
  host_model i_host (.mclk(mclk), .host_rd(host_rd), .host_wr(host_wr),
    .rd_data(rd_data));
  touch_status_register i_dut (.mclk(mclk), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .result_store(st), .result_read(rr),
    .host_rd(host_rd), .host_wr(host_wr), .bias_power_down_select(sel),
    .pen_touch(pen_touch), .conv_start(conv_start),
    .conv_active(conv_active), .set_done(set_done), .rd_data(rd_data),
    .bias_on(bias_on));
  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic poll(logic [15:0] e);
    i_host.read_reg(4'h8, d);
    cmp("status", e, d);
  endtask
  task automatic pulse(ref logic s);
    @(posedge mclk) #1 s = 1'b1;
    @(posedge mclk) #1 s = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      summarize();
    end
  end
  initial
  begin
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    poll(16'h0004);
    poll(16'h0084);
    i_host.write_reg();
    poll(16'h0084);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge mclk) #1 st = 5'b1 << i;
      @(posedge mclk) #1 st = '0;
      poll(16'h0084 | (16'h0800 << i));
      @(posedge mclk) #1 rr = 5'b1 << i;
      @(posedge mclk) #1 rr = '0;
      poll(16'h0084);
    end
    @(posedge mclk) #1 st = 5'b10000;
    @(posedge mclk) #1 st = '0;
    i_host.read_reg(4'h3, d);
    cmp("other address", 16'h0084, d);
    poll(16'h8084);
    @(posedge mclk) #1 rr = 5'b10000;
    @(posedge mclk) #1 rr = '0;
    sel = 1'b0;
    poll(16'h0084);
    conv_active = 1'b1;
    pulse(conv_start);
    cmp("bias_on", 16'h0001, {15'h0, bias_on});
    poll(16'h0080);
    conv_active = 1'b0;
    pulse(set_done);
    cmp("bias_on", 16'h0000, {15'h0, bias_on});
    sel = 1'b1;
    pulse(pen_touch);
    poll(16'h0084);
    pulse(soft_rst);
    poll(16'h0004);
    summarize();
  end
endmodule
`default_nettype wire
